// ==== hw/cws_ctrl.sv ====
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "cws_map.svh"

// ****************************************
// Complementary waveform generator control
// ****************************************
// Overview of operation
// [R01] Software sets pins input, loads gaps, trips, levels, forced shutdown first.
// [R02] Software enables, sets pins output, then restarts by auto or clearing.
// [R03] In shutdown each pin takes its override level; only the inactive code inverts.
// [R04] auto_restart_on picks software or automatic restart.
// [R05] Manual mode: stay shut until software clears, resume on rising edge.
// [R06] Software clear only works while no enabled trip is active.
// [R07] Auto mode: trips gone clears shutdown_active, resume on rising edge.
// [R08] Output control bit 7 turns the generator on or off.
// [R09] Drive enables bits 6 and 5 route each waveform to its pin.
// [R10] Invert bits 4 and 3 flip each output when set.
// [R11] Output control bit 0 selects oscillator or system clock.
// [R12] out_b override bits 7-6: high, low, float, inactive with polarity.
// [R13] out_a override bits 5-4 use the same encoding.
// [R14] Bits 1-0 select pwm chan1, chan2, nco or logic cell.
// [R15] Shutdown control bit 7 reads one while shutdown is in effect.
// [R16] Shutdown control bit 6 enables automatic restart.
// [R17] Bit 1 set lets a high logic cell output trip.
// [R18] Bit 0 set lets a low fault input trip.
// [R19] Unimplemented bits read zero and ignore writes.
// [R20] Control clears on reset; override levels keep their value.
// [R21] Rising edge: b off now, gap, then a on; zero skips.
// [R22] Falling edge: a off now, gap, then b on; short pulse drops.
// [R23] Gaps count generator clocks from zero to the six-bit value.
// [R24] Software set forces shutdown; enabled trip levels hold it.
// [R25] Sources and trips are synchronised before edge detection.
module cws_ctrl
    import cws_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pwm_chan1_out,
    input wire logic pwm_chan2_out,
    input wire logic nco_out,
    input wire logic logic_cell_out,
    input wire logic fault_in,
    input wire logic internal_hf_osc,
    output logic out_a,
    output logic out_a_oe_n,
    output logic out_b,
    output logic out_b_oe_n
);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic acc;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic [7:0] rd_mux;
    logic wr_oc;
    logic wr_os;
    logic wr_sc;
    logic [7:0] oc_q;
    logic [7:0] sc_cfg_q;
    cws_ovr_type lvl_a_q;
    cws_ovr_type lvl_b_q;
    cws_src_type src_q;
    logic [`CWS_GAP_W-1:0] rise_q;
    logic [`CWS_GAP_W-1:0] fall_q;
    logic active_q;
    logic run_q;
    logic wave;
    logic wave_prev_q;
    logic osc_prev_q;
    logic tick;
    logic trip;
    logic shut;
    logic db_a;
    logic db_b;
    logic [`CWS_SYNC_N-1:0] sync_raw;
    logic [`CWS_SYNC_N-1:0] sync_meta_q;
    logic [`CWS_SYNC_N-1:0] sync_q;
    logic [1:0] pin_q;
    logic [1:0] oe_n_q;
    logic [1:0] drv;
    logic [1:0] inv;
    logic [1:0] dbw;
    cws_ovr_type lvl [2];

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    assign acc = hsel & htrans[1] & hready;
    assign wr_oc = wr_pend_q & (addr_q == `CWS_OFS_OUT_CTRL);
    assign wr_os = wr_pend_q & (addr_q == `CWS_OFS_OVR_SRC);
    assign wr_sc = wr_pend_q & (addr_q == `CWS_OFS_SHDN_CTRL);

    // Address phase capture
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= 8'h00;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= acc & hwrite;
            rd_pend_q <= acc & ~hwrite;
            if (acc) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Reads take one wait state so a write just before is seen
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            hreadyout <= ~(acc & ~hwrite);
            hresp <= 1'b0;
            if (rd_pend_q) begin
                hrdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // [R19] rebuilt read value
    always_comb begin
        case (addr_q)
            `CWS_OFS_OUT_CTRL: rd_mux = oc_q;
            `CWS_OFS_OVR_SRC: rd_mux = {lvl_b_q, lvl_a_q, 2'b00, src_q};
            `CWS_OFS_SHDN_CTRL: rd_mux = {active_q, sc_cfg_q[6:0]};
            `CWS_OFS_RISE_GAP: rd_mux = 8'(rise_q);
            `CWS_OFS_FALL_GAP: rd_mux = 8'(fall_q);
            default: rd_mux = 8'h00;
        endcase
    end

    // ****************************************
    // Register file
    // ****************************************
    // [R20] control clears on reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            oc_q <= `CWS_OC_RESET;
            sc_cfg_q <= `CWS_SC_RESET;
            src_q <= CWS_SRC_PWM_CHAN1;
        end else begin
            if (wr_oc) begin
                oc_q <= hwdata[7:0] & `CWS_OC_MASK;
            end
            if (wr_sc) begin
                sc_cfg_q <= hwdata[7:0] & `CWS_SC_CFG_MASK;
            end
            if (wr_os) begin
                src_q <= cws_src_type'(hwdata[`CWS_OS_SRC_HI:`CWS_OS_SRC_LO]);
            end
        end
    end

    // [R20] override kept over reset
    always_ff @(posedge clk_sys) begin
        if (wr_os) begin
            lvl_b_q <= cws_ovr_type'(hwdata[`CWS_OS_LVL_B_HI:`CWS_OS_LVL_B_LO]);
            lvl_a_q <= cws_ovr_type'(hwdata[`CWS_OS_LVL_A_HI:`CWS_OS_LVL_A_LO]);
        end
    end

    // Gap counts, not cleared by reset
    always_ff @(posedge clk_sys) begin
        if (wr_pend_q && addr_q == `CWS_OFS_RISE_GAP) begin
            rise_q <= hwdata[`CWS_GAP_W-1:0];
        end
        if (wr_pend_q && addr_q == `CWS_OFS_FALL_GAP) begin
            fall_q <= hwdata[`CWS_GAP_W-1:0];
        end
    end

    // ****************************************
    // Input synchronisers and source select
    // ****************************************
    assign sync_raw = {internal_hf_osc, fault_in, logic_cell_out,
                       nco_out, pwm_chan2_out, pwm_chan1_out};

    // [R25] two-stage sync per input
    for (genvar g = 0; g < `CWS_SYNC_N; g++) begin : g_sync
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                sync_meta_q[g] <= 1'b0;
                sync_q[g] <= 1'b0;
            end else begin
                sync_meta_q[g] <= sync_raw[g];
                sync_q[g] <= sync_meta_q[g];
            end
        end
    end

    // Oscillator must run below half of clk_sys to be counted
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= sync_q[5];
        end
    end

    // [R11] generator clock select
    assign tick = oc_q[`CWS_OC_CLK_SEL] ? (sync_q[5] & ~osc_prev_q) : 1'b1;

    // [R14] waveform source mux
    always_comb begin
        case (src_q)
            CWS_SRC_PWM_CHAN1: wave = sync_q[0];
            CWS_SRC_PWM_CHAN2: wave = sync_q[1];
            CWS_SRC_NCO: wave = sync_q[2];
            CWS_SRC_LOGIC_CELL: wave = sync_q[3];
            default: wave = 1'b0;
        endcase
    end

    // [R17] [R18] level trips
    assign trip = (sc_cfg_q[`CWS_SC_LC_TRIP] & sync_q[3])
                | (sc_cfg_q[`CWS_SC_FLT_TRIP] & ~sync_q[4]);

    // ****************************************
    // Shutdown and restart
    // ****************************************
    // [R24] trip set beats any clear
    // [R06] [R07] [R15] [R16] status bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else if (trip) begin
            active_q <= 1'b1;
        end else if (wr_sc) begin
            active_q <= hwdata[`CWS_SC_ACTIVE];
        end else if (sc_cfg_q[`CWS_SC_AUTO]) begin
            active_q <= 1'b0;
        end
    end

    // [R05] resume on first rising edge
    // [R04] restart gated by status
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            wave_prev_q <= 1'b0;
        end else begin
            wave_prev_q <= wave;
            if (!oc_q[`CWS_OC_GEN_ON] || active_q || trip) begin
                run_q <= 1'b0;
            end else if (wave && !wave_prev_q) begin
                run_q <= 1'b1;
            end
        end
    end

    // Trip acts at once, not after the status flop
    assign shut = ~run_q | trip;

    // ****************************************
    // Dead band and pin drive
    // ****************************************
    cws_dead_band #(
        .GAP_W(`CWS_GAP_W)
    ) u_gap (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(run_q),
        .level(wave),
        .tick(tick),
        .rise_gap(rise_q),
        .fall_gap(fall_q),
        .wave_a(db_a),
        .wave_b(db_b)
    );

    assign drv = {oc_q[`CWS_OC_DRV_B], oc_q[`CWS_OC_DRV_A]};
    assign inv = {oc_q[`CWS_OC_INV_B], oc_q[`CWS_OC_INV_A]};
    assign dbw = {db_b, db_a};
    assign lvl[0] = lvl_a_q;
    assign lvl[1] = lvl_b_q;

    // Channel 0 is out_a, channel 1 is out_b
    for (genvar c = 0; c < 2; c++) begin : g_pin
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                pin_q[c] <= 1'b0;
                oe_n_q[c] <= 1'b1;
            end else if (!(oc_q[`CWS_OC_GEN_ON] && drv[c])) begin
                // [R08] [R09] pin released
                pin_q[c] <= 1'b0;
                oe_n_q[c] <= 1'b1;
            end else if (shut) begin
                // [R03] [R12] [R13] override level
                case (lvl[c])
                    CWS_OVR_HIGH: begin
                        pin_q[c] <= 1'b1;
                        oe_n_q[c] <= 1'b0;
                    end
                    CWS_OVR_LOW: begin
                        pin_q[c] <= 1'b0;
                        oe_n_q[c] <= 1'b0;
                    end
                    CWS_OVR_TRI: begin
                        pin_q[c] <= 1'b0;
                        oe_n_q[c] <= 1'b1;
                    end
                    default: begin
                        pin_q[c] <= inv[c];
                        oe_n_q[c] <= 1'b0;
                    end
                endcase
            end else begin
                // [R10] polarity on live waveform
                pin_q[c] <= dbw[c] ^ inv[c];
                oe_n_q[c] <= 1'b0;
            end
        end
    end

    assign out_a = pin_q[0];
    assign out_a_oe_n = oe_n_q[0];
    assign out_b = pin_q[1];
    assign out_b_oe_n = oe_n_q[1];

    // ****************************************
    // Checks
    // ****************************************
    sequence s_db_rise_n4;
        run_q && $past(run_q) && wave && !wave_prev_q
            && !oc_q[`CWS_OC_CLK_SEL] && rise_q == 6'd4;
    endsequence

    sequence s_restart_ready;
        oc_q[`CWS_OC_GEN_ON] && !run_q && !active_q && !trip;
    endsequence

    a_trip_high_level: assert property ( // [R03]
        (trip && oc_q[`CWS_OC_GEN_ON] && drv[0] && lvl_a_q == CWS_OVR_HIGH)
            |=> (out_a && !out_a_oe_n))
        else $error("out_a not at high override during trip");

    a_trip_sets_flag: assert property ( // [R24]
        trip |=> active_q)
        else $error("trip did not set shutdown flag");

    a_clear_blocked: assert property ( // [R06]
        (wr_sc && !hwdata[`CWS_SC_ACTIVE] && trip) |=> active_q)
        else $error("shutdown cleared while trip active");

    a_auto_clears: assert property ( // [R07]
        (active_q && sc_cfg_q[`CWS_SC_AUTO] && !trip && !wr_sc) |=> !active_q)
        else $error("auto restart did not clear flag");

    a_manual_holds: assert property ( // [R05]
        (active_q && !sc_cfg_q[`CWS_SC_AUTO] && !wr_sc) |=> active_q)
        else $error("manual shutdown cleared by itself");

    a_resume_edge: assert property ( // [R05]
        (s_restart_ready ##0 (wave && !wave_prev_q)) |=> run_q)
        else $error("no resume on rising edge");

    a_gap_hold: assert property ( // [R21]
        s_db_rise_n4 |=> !db_a [*4])
        else $error("out_a on before rise gap");

    a_gap_end: assert property ( // [R23]
        (s_db_rise_n4 ##1 (wave && run_q && rise_q == 6'd4) [*4]) |=> db_a)
        else $error("out_a late after rise gap");

    a_gen_off_float: assert property ( // [R08]
        !oc_q[`CWS_OC_GEN_ON] |=> (out_a_oe_n && out_b_oe_n))
        else $error("pins driven while generator off");

    a_invert_live: assert property ( // [R10]
        (!shut && oc_q[`CWS_OC_GEN_ON] && drv[1])
            |=> (out_b == ($past(db_b) ^ $past(inv[1]))))
        else $error("out_b polarity wrong");

endmodule : cws_ctrl

// ==== hw/cws_map.svh ====
`ifndef CWS_MAP_SVH
`define CWS_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CWS_OFS_OUT_CTRL 8'h00
`define CWS_OFS_OVR_SRC 8'h04
`define CWS_OFS_SHDN_CTRL 8'h08
`define CWS_OFS_RISE_GAP 8'h0C
`define CWS_OFS_FALL_GAP 8'h10

// ****************************************
// Field positions
// ****************************************
`define CWS_OC_GEN_ON 7
`define CWS_OC_DRV_B 6
`define CWS_OC_DRV_A 5
`define CWS_OC_INV_B 4
`define CWS_OC_INV_A 3
`define CWS_OC_CLK_SEL 0
`define CWS_OS_LVL_B_HI 7
`define CWS_OS_LVL_B_LO 6
`define CWS_OS_LVL_A_HI 5
`define CWS_OS_LVL_A_LO 4
`define CWS_OS_SRC_HI 1
`define CWS_OS_SRC_LO 0
`define CWS_SC_ACTIVE 7
`define CWS_SC_AUTO 6
`define CWS_SC_LC_TRIP 1
`define CWS_SC_FLT_TRIP 0

// ****************************************
// Writable masks, reset values and widths
// ****************************************
`define CWS_OC_MASK 8'hF9
`define CWS_SC_CFG_MASK 8'h43
`define CWS_OC_RESET 8'h00
`define CWS_SC_RESET 8'h00
`define CWS_SRC_RESET 2'b00
`define CWS_GAP_W 6
`define CWS_SYNC_N 6

`endif

// ==== hw/cws_pkg.sv ====
package cws_pkg;

    // Override level codes of each output during shutdown
    typedef enum logic [1:0] {
        CWS_OVR_INACTIVE = 2'b00,
        CWS_OVR_TRI = 2'b01,
        CWS_OVR_LOW = 2'b10,
        CWS_OVR_HIGH = 2'b11
    } cws_ovr_type;

    // Waveform source codes
    typedef enum logic [1:0] {
        CWS_SRC_PWM_CHAN1 = 2'b00,
        CWS_SRC_PWM_CHAN2 = 2'b01,
        CWS_SRC_NCO = 2'b10,
        CWS_SRC_LOGIC_CELL = 2'b11
    } cws_src_type;

    // Dead-band sequencer states, one-hot
    typedef enum logic [4:0] {
        CWS_DB_IDLE = 5'b00001,
        CWS_DB_RISE = 5'b00010,
        CWS_DB_A_ON = 5'b00100,
        CWS_DB_FALL = 5'b01000,
        CWS_DB_B_ON = 5'b10000
    } cws_db_state_type;

endpackage : cws_pkg

// ==== hw/cws_dead_band.sv ====
`timescale 1ns/1ps

module cws_dead_band
    import cws_pkg::*;
#(
    parameter int GAP_W = 6
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic level,
    input wire logic tick,
    input wire logic [GAP_W-1:0] rise_gap,
    input wire logic [GAP_W-1:0] fall_gap,
    output logic wave_a,
    output logic wave_b
);

    cws_db_state_type state_q, state_d;
    logic [GAP_W-1:0] cnt_q, cnt_d;
    logic lvl_q;
    logic rise;
    logic fall;

    // Previous level; forced low while idle so a restart sees an edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= 1'b0;
        end else begin
            lvl_q <= run & level;
        end
    end

    assign rise = run & level & ~lvl_q;
    assign fall = run & ~level & lvl_q;

    // Sequencer: an edge restarts its matching gap, or skips it when that gap is zero
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (!run) begin
            state_d = CWS_DB_IDLE;
            cnt_d = '0;
        end else if (rise) begin
            // [R21] rise kills b
            cnt_d = '0;
            state_d = (rise_gap == '0) ? CWS_DB_A_ON : CWS_DB_RISE;
        end else if (fall) begin
            // [R22] fall kills a
            cnt_d = '0;
            state_d = (fall_gap == '0) ? CWS_DB_B_ON : CWS_DB_FALL;
        end else begin
            case (state_q)
                CWS_DB_IDLE, CWS_DB_A_ON, CWS_DB_B_ON: begin
                    state_d = state_q;
                end
                CWS_DB_RISE: begin
                    // [R23] count rise gap
                    if (tick) begin
                        if (cnt_q == rise_gap - GAP_W'(1)) begin
                            state_d = CWS_DB_A_ON;
                        end else begin
                            cnt_d = cnt_q + GAP_W'(1);
                        end
                    end
                end
                CWS_DB_FALL: begin
                    // [R23] count fall gap
                    if (tick) begin
                        if (cnt_q == fall_gap - GAP_W'(1)) begin
                            state_d = CWS_DB_B_ON;
                        end else begin
                            cnt_d = cnt_q + GAP_W'(1);
                        end
                    end
                end
                default: begin
                    state_d = CWS_DB_IDLE;
                end
            endcase
        end
    end

    // State and counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CWS_DB_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign wave_a = (state_q == CWS_DB_A_ON);
    assign wave_b = (state_q == CWS_DB_B_ON);

endmodule : cws_dead_band

// ==== verification/cws_src_model.sv ====
`timescale 1ns/1ps

// ********
// Waveform source model
// ********
module cws_src_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [7:0] half,
    output logic wave
);
    logic [7:0] cnt_q;

    // Square wave; parks low when stopped, like an idle timer output
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            wave <= 1'b0;
        end else if (!run) begin
            cnt_q <= 8'h00;
            wave <= 1'b0;
        end else if (cnt_q >= half) begin
            cnt_q <= 8'h00;
            wave <= ~wave;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : cws_src_model

// ==== verification/tb_complementary_waveform_shutdown_ctrl.sv ====
`timescale 1ns/1ps
`include "cws_map.svh"

`define TB_CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_complementary_waveform_shutdown_ctrl;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [3:1] src_tb = 3'b000; // chan2, nco, logic cell
    logic fault_in = 1'b1;
    logic osc = 1'b0;
    logic src_run = 1'b0;
    logic hreadyout, hresp, pwm1, out_a, out_a_oe_n, out_b, out_b_oe_n;
    logic [31:0] hrdata;
    logic [7:0] rd;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    // ********
    // Clock, oscillator, timeout
    // ********
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // Oscillator at a quarter of the system rate, within the sampled limit
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc[0]) begin
            osc <= ~osc;
        end
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    cws_src_model cws_src_model_inst (.clk_sys, .rst_n, .run(src_run), .half(8'h14), .wave(pwm1));

    cws_ctrl cws_ctrl_inst (
        .clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pwm_chan1_out(pwm1),
        .pwm_chan2_out(src_tb[1]), .nco_out(src_tb[2]), .logic_cell_out(src_tb[3]),
        .fault_in, .internal_hf_osc(osc), .out_a, .out_a_oe_n, .out_b, .out_b_oe_n
    );

    // ********
    // Bus and wait helpers
    // ********
    // Single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h00_0000, wd};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        `TB_CHECK(rd, exp)
        `TB_CHECK(hresp, 1'b0)
    endtask : rchk

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle

    // Cycles until a pin shows a level, capped so a stuck pin fails later
    task automatic wait_pin(input bit on_a, input logic lvl, output int n);
        n = 0;
        while (((on_a ? out_a : out_b) !== lvl) && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
    endtask : wait_pin

    // ********
    // Scenarios
    // ********
    // reset values and reserved bits
    task automatic t_regs();
        rchk(`CWS_OFS_OUT_CTRL, 8'h00);
        rchk(`CWS_OFS_SHDN_CTRL, 8'h00);
        bus(1'b0, `CWS_OFS_OVR_SRC, 8'h00);
        `TB_CHECK(rd[3:0], 4'h0)
        wr(`CWS_OFS_OUT_CTRL, 8'hFF);
        rchk(`CWS_OFS_OUT_CTRL, 8'hF9);
        wr(`CWS_OFS_OVR_SRC, 8'hFF);
        rchk(`CWS_OFS_OVR_SRC, 8'hF3);
        wr(`CWS_OFS_SHDN_CTRL, 8'hFF);
        rchk(`CWS_OFS_SHDN_CTRL, 8'h43);
        wr(`CWS_OFS_RISE_GAP, 8'hFF);
        rchk(`CWS_OFS_RISE_GAP, 8'h3F);
        wr(8'h20, 8'hFF);
        rchk(8'h20, 8'h00);
        wr(`CWS_OFS_SHDN_CTRL, 8'h00);
        wr(`CWS_OFS_OUT_CTRL, 8'h00);
        $display("test regs done");
    endtask : t_regs

    // start from forced shutdown, then clear it
    task automatic t_setup();
        wr(`CWS_OFS_RISE_GAP, 8'h04);
        wr(`CWS_OFS_FALL_GAP, 8'h03);
        wr(`CWS_OFS_OVR_SRC, 8'h00);
        wr(`CWS_OFS_SHDN_CTRL, 8'h80);
        wr(`CWS_OFS_OUT_CTRL, 8'hE0);
        wr(`CWS_OFS_SHDN_CTRL, 8'h00);
        rchk(`CWS_OFS_SHDN_CTRL, 8'h00);
        src_run <= 1'b1;
        $display("test setup done");
    endtask : t_setup

    // gap between one output off and the other on
    task automatic t_dead_band();
        int n;
        wait_pin(1'b0, 1'b1, n);
        wait_pin(1'b0, 1'b0, n);
        wait_pin(1'b1, 1'b1, n);
        `TB_CHECK(n, 4)
        wait_pin(1'b1, 1'b0, n);
        wait_pin(1'b0, 1'b1, n);
        `TB_CHECK(n, 3)
        `TB_CHECK({out_a_oe_n, out_b_oe_n}, 2'b00)
        $display("test dead band done");
    endtask : t_dead_band

    // each source code steers the outputs
    task automatic t_sources();
        int n;
        wr(`CWS_OFS_RISE_GAP, 8'h00);
        wr(`CWS_OFS_FALL_GAP, 8'h00);
        src_run <= 1'b0;
        idle(30);
        for (int k = 0; k < 4; k++) begin
            wr(`CWS_OFS_OVR_SRC, k[7:0]);
            if (k == 0) src_run <= 1'b1;
            else src_tb[k] <= 1'b1;
            wait_pin(1'b1, 1'b1, n);
            `TB_CHECK(out_a, 1'b1)
            src_run <= 1'b0;
            src_tb <= 3'b000;
            wait_pin(1'b0, 1'b1, n);
            `TB_CHECK(out_b, 1'b1)
        end
        $display("test sources done");
    endtask : t_sources

    // override codes with both outputs inverted
    task automatic t_override();
        logic [1:0] ka;
        logic [1:0] kb;
        wr(`CWS_OFS_OUT_CTRL, 8'hF8);
        idle(6);
        `TB_CHECK({out_a, out_b}, 2'b10)
        for (int k = 0; k < 4; k++) begin
            ka = k[1:0];
            kb = ~ka;
            wr(`CWS_OFS_OVR_SRC, {kb, ka, 4'h0});
            wr(`CWS_OFS_SHDN_CTRL, 8'h80);
            idle(4);
            rchk(`CWS_OFS_SHDN_CTRL, 8'h80);
            `TB_CHECK(out_a_oe_n, ka == 2'b01)
            `TB_CHECK(out_b_oe_n, kb == 2'b01)
            if (ka != 2'b01) `TB_CHECK(out_a, ka != 2'b10)
            if (kb != 2'b01) `TB_CHECK(out_b, kb != 2'b10)
            wr(`CWS_OFS_SHDN_CTRL, 8'h00);
        end
        wr(`CWS_OFS_OUT_CTRL, 8'hE0);
        $display("test override done");
    endtask : t_override

    task automatic t_trip_manual();
        int n;
        wr(`CWS_OFS_OVR_SRC, 8'hB0);
        fault_in <= 1'b0;
        idle(4);
        rchk(`CWS_OFS_SHDN_CTRL, 8'h00);
        wr(`CWS_OFS_SHDN_CTRL, 8'h01);
        idle(4);
        rchk(`CWS_OFS_SHDN_CTRL, 8'h81);
        `TB_CHECK({out_a, out_b}, 2'b10)
        wr(`CWS_OFS_SHDN_CTRL, 8'h01);
        rchk(`CWS_OFS_SHDN_CTRL, 8'h81);
        fault_in <= 1'b1;
        idle(4);
        wr(`CWS_OFS_SHDN_CTRL, 8'h01);
        rchk(`CWS_OFS_SHDN_CTRL, 8'h01);
        idle(20);
        `TB_CHECK(out_b, 1'b0)
        src_run <= 1'b1;
        wait_pin(1'b0, 1'b1, n);
        `TB_CHECK(out_b, 1'b1)
        src_run <= 1'b0;
        $display("test manual trip done");
    endtask : t_trip_manual

    // logic cell trip with automatic restart
    task automatic t_trip_auto();
        wr(`CWS_OFS_SHDN_CTRL, 8'h40);
        src_tb[3] <= 1'b1;
        idle(4);
        rchk(`CWS_OFS_SHDN_CTRL, 8'h40);
        wr(`CWS_OFS_SHDN_CTRL, 8'h42);
        idle(4);
        rchk(`CWS_OFS_SHDN_CTRL, 8'hC2);
        src_tb[3] <= 1'b0;
        idle(4);
        rchk(`CWS_OFS_SHDN_CTRL, 8'h42);
        wr(`CWS_OFS_SHDN_CTRL, 8'hC2);
        idle(3);
        rchk(`CWS_OFS_SHDN_CTRL, 8'h42);
        wr(`CWS_OFS_SHDN_CTRL, 8'h00);
        $display("test auto trip done");
    endtask : t_trip_auto

    // gap counted in oscillator ticks, four system cycles each
    task automatic t_clk_osc();
        int n;
        wr(`CWS_OFS_OVR_SRC, 8'h00);
        wr(`CWS_OFS_RISE_GAP, 8'h02);
        wr(`CWS_OFS_OUT_CTRL, 8'hE1);
        src_run <= 1'b1;
        wait_pin(1'b0, 1'b1, n);
        wait_pin(1'b0, 1'b0, n);
        wait_pin(1'b1, 1'b1, n);
        `TB_CHECK(n >= 4 && n <= 12, 1'b1)
        src_run <= 1'b0;
        wr(`CWS_OFS_OUT_CTRL, 8'hE0);
        $display("test clock select done");
    endtask : t_clk_osc

    // pulse shorter than the gap never turns out_a on
    task automatic t_short_pulse();
        int n;
        logic hit;
        hit = 1'b0;
        wr(`CWS_OFS_OVR_SRC, 8'h02);
        wr(`CWS_OFS_RISE_GAP, 8'h0A);
        wait_pin(1'b0, 1'b1, n);
        src_tb[2] <= 1'b1;
        idle(3);
        src_tb[2] <= 1'b0;
        repeat (40) begin
            @(posedge clk_sys);
            if (out_a !== 1'b0) hit = 1'b1;
        end
        `TB_CHECK(hit, 1'b0)
        $display("test short pulse done");
    endtask : t_short_pulse

    task automatic t_gen_off();
        wr(`CWS_OFS_OUT_CTRL, 8'hA0);
        idle(4);
        `TB_CHECK({out_a_oe_n, out_b_oe_n}, 2'b01)
        wr(`CWS_OFS_OUT_CTRL, 8'h60);
        idle(4);
        `TB_CHECK({out_a_oe_n, out_b_oe_n}, 2'b11)
        $display("test generator off done");
    endtask : t_gen_off

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_setup();
        t_dead_band();
        t_sources();
        t_override();
        t_trip_manual();
        t_trip_auto();
        t_clk_osc();
        t_short_pulse();
        t_gen_off();
        complete_run();
    end
endmodule : tb_complementary_waveform_shutdown_ctrl
